// *** hart_host_model.sv ***
// Host side of the register port: a communicator issuing reads and writes.
// Assumes read data stand in the cycle after the read strobe.
module hart_host_model (
	input  wire logic        core_clk_in, // Core clock
	input  wire logic [31:0] rdata_in,    // Device read data
	output logic      [7:0]  addr_out,    // Byte address
	output logic      [31:0] wdata_out,   // Write data
	output logic             wr_out,      // Write strobe
	output logic             rd_out       // Read strobe
);
	timeunit 1ns;
	timeprecision 100ps;

	// Point-to-point loop, so only device address 0 is polled
	localparam bit [5:0] HOST_POLL = 6'h00;

	initial begin
		addr_out = 8'h00;
		wdata_out = 32'h00000000;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end

	// Extra edge at the end so registered effects are visible on return
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge core_clk_in);
		wr_out <= 1'b0;
		wdata_out <= ~d;
		@(posedge core_clk_in);
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge core_clk_in);
		rd_out <= 1'b0;
		// Data stand only until the next rising edge; take them mid-cycle to avoid the update race
		@(negedge core_clk_in);
		d = rdata_in;
		@(posedge core_clk_in);
	endtask
endmodule

// *** icp_map.svh ***
// Constants of the configuration and protection block: offsets, bits, times.
// Assumes a 250 MHz core clock and a byte-addressed register port.
//
// Notes on behaviour
// - Two service modes; in service follows loop signal, out of service for setup.
// - Some changes made out of service wait until return to service or restart.
// - Protection defaults off; when on, every configuration and calibration write is refused.
// - Remote command sets protection; clearing also needs a local button press.
// - Short tag of up to 8 characters stored and shown to the communicator.
// - Long tag of up to 32 characters exists only under protocol revision 7.
// - Description field holds up to 16 characters.
// - Message field holds up to 32 characters.
// - Polling address 0 to 63 under revision 7, 0 to 15 under revision 5.
// - Polling address change refused unless out of service.
// - Instrument and valve serial numbers hold up to 12 characters each.
// - Button held 3 to 10 seconds starts autocalibration over full travel.
// - Button autocalibration runs whether in service or out of service.
// - Button calibration and abort ignored while protected; both disabled by default.
// - During autocalibration a 1 second press aborts it.
// - Auxiliary short of 3 to 10 seconds starts a partial stroke test.
// - Auxiliary terminals may instead serve a local control panel.
// - Settable 24-hour clock stamps each stored alert record with time and date.
// - Analog input reported in mA or percent of 4-20 mA span.
// - Pressure reported in psi, bar, kPa or kg/cm2.
`ifndef ICP_MAP_SVH
`define ICP_MAP_SVH

`define OFS_CTRL   8'h00
`define OFS_STAT   8'h04
`define OFS_PEND   8'h08
`define OFS_ACT    8'h0C
`define OFS_TIME   8'h10
`define OFS_DATE   8'h14
`define OFS_RCODE  8'h18
`define OFS_RTIME  8'h1C
`define OFS_RDATE  8'h20
`define STR_SEL    7

`define C_OOS      0
`define C_PROT     1
`define C_UNPROT   2
`define C_RESTART  3
`define C_CLRREJ   4
`define C_CAL      5

`define LTAG_LO    7'h08
`define LTAG_HI    7'h27
`define STR_TOP    7'h6F

`define CFG_RST    16'h0000
`define POLL_MAX7  6'h3F
`define POLL_MAX5  6'h0F
`define HOUR_MAX   5'h17
`define MSEC_MAX   6'h3B

`define CLK_HZ     64'h0EE6B280
`define PRESS_MIN_S 64'h3
`define PRESS_MAX_S 64'hA
`define ABORT_S    64'h1
`define TICK_S     64'h1
`define CNT_SAT    32'hFFFFFFFF

`endif

// *** icp_pkg.sv ***
// Types of the configuration and protection block.
// Assumes icp_map.svh gives the matching offsets and constants.
package icp_pkg;

	typedef enum logic {CAL_IDLE, CAL_RUN} cal_st_t;

	// Layout equals the configuration word, bit 0 upward from the bottom field
	typedef struct packed {
		logic       rsv_hi;
		logic       rev7;
		logic       aux_panel;
		logic       cal_en;
		logic       temp_c;
		logic [1:0] punit;
		logic       ai_pct;
		logic [1:0] rsv_lo;
		logic [5:0] poll;
	} cfg_t;

	typedef struct packed {
		logic [10:0] rsv2;
		logic [4:0]  hour;
		logic [1:0]  rsv1;
		logic [5:0]  min;
		logic [1:0]  rsv0;
		logic [5:0]  sec;
	} tword_t;

	typedef struct packed {
		logic [25:0] rsv;
		logic        rev7;
		logic        pend_diff;
		logic        rej;
		logic        cal;
		logic        prot;
		logic        oos;
	} stat_t;

	typedef struct packed {
		logic        oos;
		logic        prot;
		logic        unprot_arm;
		logic        rej;
		cfg_t        pend;
		cfg_t        act;
		cal_st_t     cal;
		logic        cal_start;
		logic        cal_abort;
		logic        pst_start;
		logic        abort_used;
		logic        btn_s1;
		logic        btn_s2;
		logic        aux_s1;
		logic        aux_s2;
		logic [31:0] btn_cnt;
		logic [31:0] aux_cnt;
		logic [31:0] tick;
		tword_t      tod;
		logic [15:0] date;
		logic [7:0]  rec_code;
		tword_t      rec_t;
		logic [15:0] rec_date;
		logic [31:0] rdata;
	} state_t;

endpackage

// *** instrument_config_protection.sv ***
// Mode, write protection, identification strings, units, button timing and clock.
// Assumes a synchronous register master on core_clk_in; button and aux pins are asynchronous.
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`include "icp_map.svh"

module instrument_config_protection #(
	parameter bit [31:0] PRESS_MIN_CYC = 32'(`PRESS_MIN_S * `CLK_HZ),
	parameter bit [31:0] PRESS_MAX_CYC = 32'(`PRESS_MAX_S * `CLK_HZ),
	parameter bit [31:0] ABORT_CYC     = 32'(`ABORT_S * `CLK_HZ),
	parameter bit [31:0] TICK_CYC      = 32'(`TICK_S * `CLK_HZ)
) (
	input  wire logic        core_clk_in,    // Core clock
	input  wire logic        rstn_in,        // Async reset, low
	input  wire logic [7:0]  addr_in,        // Register byte address
	input  wire logic [31:0] wdata_in,       // Write data
	input  wire logic        wr_in,          // Write strobe
	input  wire logic        rd_in,          // Read strobe
	input  wire logic        cal_button_in,  // Terminal box button, high pressed
	input  wire logic        aux_short_in,   // Aux terminals shorted, high
	input  wire logic        cal_done_in,    // Autocalibration finished pulse
	input  wire logic        alert_event_in, // Alert to record pulse
	input  wire logic [7:0]  alert_code_in,  // Alert code
	output logic      [31:0] rdata_out,      // Read data, cycle after rd
	output logic             in_service_out, // Tracks loop signal
	output logic             protected_out,  // Write protection on
	output logic             cal_active_out, // Autocalibration running
	output logic             cal_start_out,  // Start calibration pulse
	output logic             cal_abort_out,  // Abort calibration pulse
	output logic             pst_start_out,  // Start partial stroke pulse
	output logic             aux_panel_out,  // Aux terminals serve panel
	output logic      [5:0]  poll_addr_out,  // Active polling address
	output logic             ai_percent_out, // Analog input in percent
	output logic      [1:0]  press_unit_out, // 0 psi 1 bar 2 kPa 3 kg/cm2
	output logic             temp_c_out      // Temperature in Celsius
);

	icp_pkg::state_t s;
	icp_pkg::state_t n;
	logic [7:0]      str_mem [0:`STR_TOP];
	logic [6:0]      idx;
	logic            str_ok;
	logic            str_we;
	logic [7:0]      str_rd;
	logic            btn_rel;
	logic            aux_rel;
	logic            btn_ok;
	logic            wr_ctrl;
	logic            wr_cfg;
	icp_pkg::cfg_t   wcfg;
	logic [5:0]      poll_max;
	icp_pkg::stat_t  stat;

	always_comb begin
		idx      = addr_in[6:0];
		// Long tag bytes vanish under revision 5
		str_ok   = (idx <= `STR_TOP) && (s.act.rev7 || idx < `LTAG_LO || idx > `LTAG_HI);
		str_rd   = str_ok ? str_mem[idx] : 8'h00;
		str_we   = wr_in && addr_in[`STR_SEL] && str_ok && !s.prot;
		btn_rel  = !s.btn_s2 && (s.btn_cnt != 32'h0);
		aux_rel  = !s.aux_s2 && (s.aux_cnt != 32'h0);
		btn_ok   = !s.prot && s.act.cal_en;
		wr_ctrl  = wr_in && !addr_in[`STR_SEL] && (addr_in == `OFS_CTRL);
		wr_cfg   = wr_in && !addr_in[`STR_SEL] && (addr_in == `OFS_PEND);
		wcfg     = icp_pkg::cfg_t'(wdata_in[15:0]);
		poll_max = s.act.rev7 ? `POLL_MAX7 : `POLL_MAX5;
		stat      = '0;
		stat.oos  = s.oos;
		stat.prot = s.prot;
		stat.cal  = (s.cal == icp_pkg::CAL_RUN);
		stat.rej  = s.rej;
		stat.pend_diff = (s.pend != s.act);
		stat.rev7 = s.act.rev7;
	end

	// Strings: tag, long tag, description, message, two serial numbers
	always_ff @(posedge core_clk_in) begin
		if (str_we) begin
			str_mem[idx] <= wdata_in[7:0];
		end
	end

	always_comb begin
		n           = s;
		n.cal_start = 1'b0;
		n.cal_abort = 1'b0;
		n.pst_start = 1'b0;
		n.rdata     = 32'h0;
		n.btn_s1    = cal_button_in;
		n.btn_s2    = s.btn_s1;
		n.aux_s1    = aux_short_in;
		n.aux_s2    = s.aux_s1;

		// Saturating hold counters; a stuck contact never wraps into the window
		if (s.btn_s2) begin
			n.btn_cnt = (s.btn_cnt == `CNT_SAT) ? s.btn_cnt : s.btn_cnt + 32'h1;
		end else begin
			n.btn_cnt = 32'h0;
		end
		if (s.aux_s2) begin
			n.aux_cnt = (s.aux_cnt == `CNT_SAT) ? s.aux_cnt : s.aux_cnt + 32'h1;
		end else begin
			n.aux_cnt = 32'h0;
		end

		if (s.cal == icp_pkg::CAL_RUN && cal_done_in) begin
			n.cal = icp_pkg::CAL_IDLE;
		end

		// Abort fires while still held, so the press cannot also restart
		if (s.cal == icp_pkg::CAL_RUN && btn_ok && s.btn_s2 && s.btn_cnt == ABORT_CYC - 32'h1) begin
			n.cal        = icp_pkg::CAL_IDLE;
			n.cal_abort  = 1'b1;
			n.abort_used = 1'b1;
		end

		if (btn_rel) begin
			n.abort_used = 1'b0;
			// Start ignores service mode on purpose
			if (!s.abort_used && btn_ok && s.cal == icp_pkg::CAL_IDLE &&
				s.btn_cnt >= PRESS_MIN_CYC && s.btn_cnt <= PRESS_MAX_CYC) begin
				n.cal       = icp_pkg::CAL_RUN;
				n.cal_start = 1'b1;
			end
			// Physical presence completes an armed unprotect request
			if (s.prot && s.unprot_arm) begin
				n.prot       = 1'b0;
				n.unprot_arm = 1'b0;
			end
		end

		if (aux_rel && !s.act.aux_panel &&
			s.aux_cnt >= PRESS_MIN_CYC && s.aux_cnt <= PRESS_MAX_CYC) begin
			n.pst_start = 1'b1;
		end

		// Time of day; a write below overrides the tick
		if (s.tick == TICK_CYC - 32'h1) begin
			n.tick = 32'h0;
			if (s.tod.sec == `MSEC_MAX) begin
				n.tod.sec = 6'h00;
				if (s.tod.min == `MSEC_MAX) begin
					n.tod.min = 6'h00;
					if (s.tod.hour == `HOUR_MAX) begin
						n.tod.hour = 5'h00;
						n.date     = s.date + 16'h1;
					end else begin
						n.tod.hour = s.tod.hour + 5'h1;
					end
				end else begin
					n.tod.min = s.tod.min + 6'h1;
				end
			end else begin
				n.tod.sec = s.tod.sec + 6'h1;
			end
		end else begin
			n.tick = s.tick + 32'h1;
		end

		if (alert_event_in) begin
			n.rec_code = alert_code_in;
			n.rec_t    = n.tod;
			n.rec_date = n.date;
		end

		if (wr_ctrl) begin
			n.oos = wdata_in[`C_OOS];
			if (wdata_in[`C_CLRREJ]) begin
				n.rej = 1'b0;
			end
			if (wdata_in[`C_PROT]) begin
				n.prot = 1'b1;
			end
			if (wdata_in[`C_UNPROT] && s.prot) begin
				n.unprot_arm = 1'b1;
			end
			// Pending set takes effect on return to service or restart
			if ((s.oos && !wdata_in[`C_OOS]) || wdata_in[`C_RESTART]) begin
				n.act = s.pend;
			end
			if (wdata_in[`C_CAL]) begin
				if (s.prot) begin
					n.rej = 1'b1;
				end else if (s.cal == icp_pkg::CAL_IDLE) begin
					n.cal       = icp_pkg::CAL_RUN;
					n.cal_start = 1'b1;
				end
			end
		end

		if (wr_cfg) begin
			if (s.prot) begin
				n.rej = 1'b1;
			end else begin
				n.pend        = wcfg;
				n.pend.rsv_hi = 1'b0;
				n.pend.rsv_lo = 2'h0;
				if (wcfg.poll != s.pend.poll && (!s.oos || wcfg.poll > poll_max)) begin
					n.pend.poll = s.pend.poll;
					n.rej       = 1'b1;
				end
			end
		end

		if (wr_in && !addr_in[`STR_SEL] && (addr_in == `OFS_TIME || addr_in == `OFS_DATE)) begin
			if (s.prot) begin
				n.rej = 1'b1;
			end else if (addr_in == `OFS_DATE) begin
				n.date = wdata_in[15:0];
			end else if (wdata_in[20:16] <= `HOUR_MAX && wdata_in[13:8] <= `MSEC_MAX &&
				wdata_in[5:0] <= `MSEC_MAX) begin
				n.tod      = icp_pkg::tword_t'(wdata_in);
				n.tod.rsv2 = 11'h000;
				n.tod.rsv1 = 2'h0;
				n.tod.rsv0 = 2'h0;
				n.tick     = 32'h0;
			end else begin
				n.rej = 1'b1;
			end
		end

		if (wr_in && addr_in[`STR_SEL] && !str_we) begin
			n.rej = 1'b1;
		end

		if (rd_in) begin
			if (addr_in[`STR_SEL]) begin
				n.rdata = {24'h000000, str_rd};
			end else begin
				case (addr_in)
					`OFS_CTRL:  n.rdata = {31'h0, s.oos};
					`OFS_STAT:  n.rdata = stat;
					`OFS_PEND:  n.rdata = {16'h0000, s.pend};
					`OFS_ACT:   n.rdata = {16'h0000, s.act};
					`OFS_TIME:  n.rdata = s.tod;
					`OFS_DATE:  n.rdata = {16'h0000, s.date};
					`OFS_RCODE: n.rdata = {24'h000000, s.rec_code};
					`OFS_RTIME: n.rdata = s.rec_t;
					`OFS_RDATE: n.rdata = {16'h0000, s.rec_date};
					default:    n.rdata = 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s      <= '0;
			s.pend <= icp_pkg::cfg_t'(`CFG_RST);
			s.act  <= icp_pkg::cfg_t'(`CFG_RST);
			s.cal  <= icp_pkg::CAL_IDLE;
		end else begin
			s <= n;
		end
	end

	assign rdata_out      = s.rdata;
	assign in_service_out = !s.oos;
	assign protected_out  = s.prot;
	assign cal_active_out = (s.cal == icp_pkg::CAL_RUN);
	assign cal_start_out  = s.cal_start;
	assign cal_abort_out  = s.cal_abort;
	assign pst_start_out  = s.pst_start;
	assign aux_panel_out  = s.act.aux_panel;
	assign poll_addr_out  = s.act.poll;
	assign ai_percent_out = s.act.ai_pct;
	assign press_unit_out = s.act.punit;
	assign temp_c_out     = s.act.temp_c;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);

	a_mode_write: assert property (wr_ctrl |=> in_service_out == !$past(wdata_in[`C_OOS]))
		else $error("service mode not taken from write");
	a_pend_apply: assert property (wr_ctrl && wdata_in[`C_RESTART] |=> s.act == $past(s.pend))
		else $error("pending configuration not applied");
	a_cfg_locked: assert property (s.prot && wr_cfg |=> $stable(s.pend) && s.rej)
		else $error("configuration changed while protected");
	a_prot_set: assert property (wr_ctrl && wdata_in[`C_PROT] |=> protected_out)
		else $error("remote protect not set");
	a_prot_hold: assert property (protected_out && !btn_rel |=> protected_out)
		else $error("protection cleared without button");
	a_poll_oos: assert property (!s.oos && wr_cfg |=> $stable(s.pend.poll))
		else $error("polling address changed in service");
	a_poll_range: assert property (wr_cfg && !s.act.rev7 && wcfg.poll > `POLL_MAX5 |=> $stable(s.pend.poll))
		else $error("polling address out of range accepted");
	a_btn_window: assert property ($rose(cal_start_out) && !$past(wr_ctrl)
		|-> $past(s.btn_cnt) >= PRESS_MIN_CYC && $past(s.btn_cnt) <= PRESS_MAX_CYC)
		else $error("calibration started outside hold window");
	a_btn_locked: assert property (s.prot ##1 !$past(wr_ctrl) |-> !cal_start_out)
		else $error("button acted while protected");
	a_abort_stop: assert property (cal_abort_out |-> !cal_active_out ##1 !cal_start_out)
		else $error("abort left calibration running");
	a_pst_window: assert property (pst_start_out |-> !aux_panel_out &&
		$past(s.aux_cnt) >= PRESS_MIN_CYC && $past(s.aux_cnt) <= PRESS_MAX_CYC)
		else $error("partial stroke started outside window");
	a_hour_bound: assert property (s.tod.hour <= `HOUR_MAX && s.tod.min <= `MSEC_MAX)
		else $error("time of day out of range");

endmodule

// *** instrument_config_protection_tb.sv ***
// Self-checking bench of the configuration and protection block.
// Assumes the host model for register traffic and shortened press windows.
`include "icp_map.svh"
module instrument_config_protection_tb;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int TK = 20;
	logic        core_clk_in = 1'b0;
	logic        rstn_in = 1'b0;
	logic        btn = 1'b0;
	logic        aux = 1'b0;
	logic        done = 1'b0;
	logic        alert = 1'b0;
	logic [7:0]  code = 8'h00;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic        ins, prot, cact, cst, cab, partial_stroke_test, panel, aip, tmpc;
	logic [5:0]  poll;
	logic [1:0]  punit;
	logic [31:0] r;
	int          bad_count = 0;
	int          checks = 0;
	int          cyc = 0;
	int          n_start = 0, n_abort = 0, n_pst = 0;
	int          es = 0, ea = 0, ep = 0;

	always #2 core_clk_in = ~core_clk_in;

	hart_host_model host_u (.core_clk_in(core_clk_in), .rdata_in(rdata), .addr_out(addr),
		.wdata_out(wdata), .wr_out(wr), .rd_out(rd));

	instrument_config_protection #(.PRESS_MIN_CYC(32'h1E), .PRESS_MAX_CYC(32'h64),
		.ABORT_CYC(32'h0A), .TICK_CYC(32'h14)) dut_u (
		.core_clk_in(core_clk_in), .rstn_in(rstn_in), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr), .rd_in(rd), .cal_button_in(btn), .aux_short_in(aux),
		.cal_done_in(done), .alert_event_in(alert), .alert_code_in(code),
		.rdata_out(rdata), .in_service_out(ins), .protected_out(prot),
		.cal_active_out(cact), .cal_start_out(cst), .cal_abort_out(cab),
		.pst_start_out(partial_stroke_test), .aux_panel_out(panel), .poll_addr_out(poll),
		.ai_percent_out(aip), .press_unit_out(punit), .temp_c_out(tmpc));

	// Pulses are one cycle wide, so counting each edge catches every one
	always @(posedge core_clk_in) begin
		cyc++;
		n_start += int'(cst === 1'b1);
		n_abort += int'(cab === 1'b1);
		n_pst += int'(partial_stroke_test === 1'b1);
		if (cyc == 10000) begin
			bad_count++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		host_u.rd_reg(a, r);
		chk(r, exp);
	endtask

	task automatic pulses();
		chk(32'(n_start), 32'(es));
		chk(32'(n_abort), 32'(ea));
		chk(32'(n_pst), 32'(ep));
	endtask

	task automatic press(input int n, input bit on_aux);
		@(posedge core_clk_in);
		if (on_aux) begin
			aux <= 1'b1;
		end else begin
			btn <= 1'b1;
		end
		repeat (n) @(posedge core_clk_in);
		aux <= 1'b0;
		btn <= 1'b0;
		repeat (8) @(posedge core_clk_in);
	endtask

	task automatic t_reset();
		chk(32'(ins), 32'h1);
		chk(32'(prot), 32'h0);
		rchk(`OFS_STAT, 32'h0);
		rchk(8'h3C, 32'h0);
		press(50, 0);
		pulses();
		$display("test reset done");
	endtask

	task automatic t_poll();
		host_u.wr_reg(`OFS_PEND, 32'h5);
		rchk(`OFS_PEND, 32'h0);
		rchk(`OFS_STAT, 32'h8);
		host_u.wr_reg(`OFS_CTRL, 32'h11);
		host_u.wr_reg(`OFS_PEND, 32'h14);
		rchk(`OFS_STAT, 32'h9);
		host_u.wr_reg(`OFS_CTRL, 32'h11);
		host_u.wr_reg(`OFS_PEND, 32'h4000);
		host_u.wr_reg(`OFS_CTRL, 32'h09);
		for (int u = 0; u < 4; u++) begin
			host_u.wr_reg(`OFS_PEND, 32'h583F | 32'(u << 9) | 32'((u & 1) << 8));
			rchk(`OFS_STAT, 32'h31);
			host_u.wr_reg(`OFS_CTRL, 32'h09);
			chk(32'(punit), 32'(u));
			chk(32'(aip), 32'(u & 1));
		end
		chk(32'(poll), 32'h3F);
		host_u.wr_reg(`OFS_PEND, 32'h573F);
		chk(32'(tmpc), 32'h1);
		host_u.wr_reg(`OFS_CTRL, 32'h00);
		chk(32'(tmpc), 32'h0);
		chk(32'(ins), 32'h1);
		$display("test poll done");
	endtask

	task automatic t_prot();
		host_u.wr_reg(`OFS_CTRL, 32'h02);
		chk(32'(prot), 32'h1);
		host_u.wr_reg(`OFS_PEND, 32'h0);
		rchk(`OFS_PEND, 32'h573F);
		host_u.wr_reg(`OFS_CTRL, 32'h20);
		press(50, 0);
		pulses();
		host_u.wr_reg(`OFS_CTRL, 32'h04);
		chk(32'(prot), 32'h1);
		rchk(`OFS_STAT, 32'h2A);
		press(5, 0);
		chk(32'(prot), 32'h0);
		host_u.wr_reg(`OFS_CTRL, 32'h10);
		$display("test protection done");
	endtask

	task automatic t_cal();
		press(25, 0);
		press(110, 0);
		pulses();
		press(50, 0);
		es++;
		pulses();
		chk(32'(cact), 32'h1);
		press(14, 0);
		ea++;
		pulses();
		chk(32'(cact), 32'h0);
		host_u.wr_reg(`OFS_CTRL, 32'h01);
		press(50, 0);
		es++;
		pulses();
		@(posedge core_clk_in);
		done <= 1'b1;
		@(posedge core_clk_in);
		done <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		chk(32'(cact), 32'h0);
		host_u.wr_reg(`OFS_CTRL, 32'h00);
		$display("test calibration done");
	endtask

	task automatic t_aux();
		press(50, 1);
		ep++;
		pulses();
		press(110, 1);
		pulses();
		host_u.wr_reg(`OFS_CTRL, 32'h01);
		host_u.wr_reg(`OFS_PEND, 32'h773F);
		host_u.wr_reg(`OFS_CTRL, 32'h00);
		chk(32'(panel), 32'h1);
		press(50, 1);
		pulses();
		$display("test aux done");
	endtask

	task automatic t_str();
		logic [7:0] ix [6];
		ix = '{8'h80, 8'hA7, 8'hB7, 8'hD7, 8'hE3, 8'hEF};
		foreach (ix[i]) begin
			host_u.wr_reg(ix[i], 32'(i) + 32'h41);
			rchk(ix[i], 32'(i) + 32'h41);
		end
		host_u.wr_reg(8'hF0, 32'h55);
		rchk(8'hF0, 32'h0);
		rchk(`OFS_STAT, 32'h28);
		host_u.wr_reg(`OFS_CTRL, 32'h11);
		host_u.wr_reg(`OFS_PEND, 32'h3700);
		host_u.wr_reg(`OFS_CTRL, 32'h00);
		host_u.wr_reg(8'h88, 32'h66);
		rchk(8'h88, 32'h0);
		$display("test strings done");
	endtask

	task automatic t_clock();
		host_u.wr_reg(`OFS_TIME, 32'h00173B32);
		host_u.wr_reg(`OFS_DATE, 32'h5);
		repeat (11 * TK) @(posedge core_clk_in);
		host_u.rd_reg(`OFS_TIME, r);
		chk(r & 32'h001F3F00, 32'h0);
		rchk(`OFS_DATE, 32'h6);
		host_u.wr_reg(`OFS_TIME, 32'h00180000);
		rchk(`OFS_STAT, 32'h08);
		@(posedge core_clk_in);
		code <= 8'hA5;
		alert <= 1'b1;
		@(posedge core_clk_in);
		alert <= 1'b0;
		rchk(`OFS_RCODE, 32'hA5);
		rchk(`OFS_RDATE, 32'h6);
		host_u.rd_reg(`OFS_RTIME, r);
		chk(r & 32'h001F3F00, 32'h0);
		$display("test clock done");
	endtask

	initial begin
		repeat (6) @(posedge core_clk_in);
		rstn_in <= 1'b1;
		t_reset();
		t_poll();
		t_prot();
		t_cal();
		t_aux();
		t_str();
		t_clock();
		report_and_stop();
	end
endmodule
